// File: rtl/dsc_decoder.sv
// serial command decoder with apb control and status
// Functional notes
// - frames are 24 bits msb first: mode, address, data field
// - frame-sync rising before 24 falling clock edges aborts the frame
// - registers load when frame-sync rises after a complete frame
// - every serial register reads back; computed values and latches do not
// - selected register shifts out via serial output during next frame
// - serial output driven from request acceptance until data fully shifted
// - each write starts a three-stage recalculation: 600, 600, 300 ns
// - multi-channel write repeats first stage 600 ns per channel
// - optional crc-8 with polynomial x^8+x^2+x+1 over the data word
// - a 32-bit frame is checked at frame-sync rise, written only if good
// - crc mismatch discards frame, pulls error output low, sets control bit 3
// - reading the control register clears the crc error and error output
// - nonzero mode writes data to register of mode in addressed channels
// - mode 11 input, 10 offset, 01 gain, 00 special function
// - input writes go to bank a or b per control bank-select bit
// - upper address 00: 000 all, 001 group 0, 010 group 1, else unused
// - upper address 01/10 pick group 0/1, lower bits pick channel; 11 unused
// - special mode: bits 21..16 function code, rest parameters
`timescale 1ns/1ps
`include "dsc_defs.svh"
module dsc_decoder
  import dsc_pkg::*;
#(
  parameter int NUM_CH = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input dsc_apb_req_s apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdi,
  output logic sdo_o,
  output logic sdo_oe,
  output logic crc_error_out_n
);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (NUM_CH != 16) begin : g_chk
    $error("dsc_decoder serves exactly 16 channels");
  end

  dsc_state_s s_r;
  dsc_state_s s_nxt;
  logic sclk_fall;
  logic sync_fall;
  logic sync_rise;
  logic crc_clr;
  logic crc_en;
  logic [7:0] crc_val;
  logic acc;
  logic mapped;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [4:0] ones(input logic [15:0] m);
    logic [4:0] n;
    n = 5'd0;
    for (int i = 0; i < 16; i++) begin
      n = n + {4'd0, m[i]};
    end
    return n;
  endfunction

  function automatic logic [15:0] addr_mask(input logic [5:0] a);
    logic [15:0] m;
    m = 16'h0000;
    if (!a[5]) begin
      case (a[4:3])
        `DSC_GRP_BCAST: begin
          case (a[2:0])
            `DSC_BC_ALL: m = 16'hffff;
            `DSC_BC_G0: m = 16'h00ff;
            `DSC_BC_G1: m = 16'hff00;
            default: m = 16'h0000;
          endcase
        end
        `DSC_GRP_0: m = 16'h0001 << a[2:0];
        `DSC_GRP_1: m = 16'h0100 << a[2:0];
        default: m = 16'h0000;
      endcase
    end
    return m;
  endfunction

  function automatic logic [15:0] ctrl_word(input logic bank, input logic err);
    logic [15:0] c;
    c = 16'h0000;
    c[`DSC_CTRL_BANK] = bank;
    c[`DSC_CTRL_CRCERR] = err;
    return c;
  endfunction

  // ---------------------------------------------------------------
  // crc engine
  // ---------------------------------------------------------------
  dsc_crc8 u_crc (
    .pclk(pclk),
    .presetn(presetn),
    .clr(crc_clr),
    .bit_en(crc_en),
    .bit_in(s_r.sdi_s),
    .crc(crc_val)
  );

  assign acc = apb_req.psel & apb_req.penable;
  assign mapped = (apb_req.paddr == `DSC_OFF_CTRL) | (apb_req.paddr == `DSC_OFF_STATUS);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [23:0] w;
    logic [15:0] m;
    logic [15:0] p;
    logic [15:0] rd;
    logic [4:0] nch;
    logic [10:0] s1;
    logic ok_len;
    logic crc_ok;
    logic end_frame;
    w = 24'h000000;
    m = 16'h0000;
    p = 16'h0000;
    rd = 16'h0000;
    nch = 5'd0;
    s1 = 11'd0;
    ok_len = 1'b0;
    crc_ok = 1'b0;
    end_frame = 1'b0;
    s_nxt = s_r;
    crc_clr = 1'b0;
    crc_en = 1'b0;

    // pin synchronisers
    s_nxt.sclk_m = sclk;
    s_nxt.sclk_s = s_r.sclk_m;
    s_nxt.sclk_d = s_r.sclk_s;
    s_nxt.sync_m = sync_n;
    s_nxt.sync_s = s_r.sync_m;
    s_nxt.sync_d = s_r.sync_s;
    s_nxt.sdi_m = sdi;
    s_nxt.sdi_s = s_r.sdi_m;
    sclk_fall = s_r.sclk_d & ~s_r.sclk_s;
    sync_fall = s_r.sync_d & ~s_r.sync_s;
    sync_rise = ~s_r.sync_d & s_r.sync_s;

    // recalculation timers
    if (s_r.s1_cnt != 11'd0) begin
      s_nxt.s1_cnt = s_r.s1_cnt - 11'd1;
    end
    if (s_r.busy_cnt != 11'd0) begin
      s_nxt.busy_cnt = s_r.busy_cnt - 11'd1;
    end

    // apb side
    if (apb_req.psel && !apb_req.penable) begin
      case (apb_req.paddr)
        `DSC_OFF_CTRL: s_nxt.prdata = {16'h0000, ctrl_word(s_r.bank, s_r.crc_err)};
        `DSC_OFF_STATUS: begin
          s_nxt.prdata = 32'h00000000;
          s_nxt.prdata[`DSC_ST_BUSY] = s_r.busy_cnt != 11'd0;
          s_nxt.prdata[`DSC_ST_STAGE1] = s_r.s1_cnt != 11'd0;
          s_nxt.prdata[`DSC_ST_PACE] = s_r.pace_err;
          s_nxt.prdata[`DSC_ST_RB] = s_r.rb_oe;
        end
        default: s_nxt.prdata = 32'h00000000;
      endcase
    end
    if (acc && !apb_req.pwrite && apb_req.paddr == `DSC_OFF_CTRL) begin
      s_nxt.crc_err = 1'b0;
    end
    if (acc && apb_req.pwrite && apb_req.paddr == `DSC_OFF_CTRL) begin
      s_nxt.bank = apb_req.pwdata[`DSC_CTRL_BANK];
    end
    if (acc && apb_req.pwrite && apb_req.paddr == `DSC_OFF_STATUS &&
        apb_req.pwdata[`DSC_ST_PACE]) begin
      s_nxt.pace_err = 1'b0;
    end

    // frame receiver
    case (s_r.fst)
      FS_IDLE: begin
        if (sync_fall) begin
          s_nxt.cnt = 6'd0;
          s_nxt.shift = 32'h00000000;
          s_nxt.fst = FS_SHIFT;
          crc_clr = 1'b1;
        end
      end
      FS_SHIFT: begin
        if (sync_rise) begin
          s_nxt.fst = FS_IDLE;
          end_frame = 1'b1;
        end else if (sclk_fall) begin
          s_nxt.shift = {s_r.shift[30:0], s_r.sdi_s};
          if (s_r.cnt != `DSC_LEN_SAT) begin
            s_nxt.cnt = s_r.cnt + 6'd1;
          end
          crc_en = s_r.cnt < `DSC_LEN_PLAIN;
          if (s_r.rb_left != 5'd0) begin
            s_nxt.rb_sh = {s_r.rb_sh[22:0], 1'b0};
            s_nxt.rb_left = s_r.rb_left - 5'd1;
            if (s_r.rb_left == 5'd1) begin
              s_nxt.rb_oe = 1'b0;
            end
          end
        end
      end
      default: s_nxt.fst = FS_IDLE;
    endcase

    // frame completion
    ok_len = (s_r.cnt == `DSC_LEN_PLAIN) | (s_r.cnt == `DSC_LEN_CRC);
    crc_ok = (s_r.cnt == `DSC_LEN_PLAIN) | (crc_val == s_r.shift[7:0]);
    w = (s_r.cnt == `DSC_LEN_CRC) ? s_r.shift[31:8] : s_r.shift[23:0];
    p = w[15:0];
    if (end_frame && ok_len) begin
      if (!crc_ok) begin
        s_nxt.crc_err = 1'b1;
      end else if (w[`DSC_MODE_HI:`DSC_MODE_LO] != `DSC_MODE_SPECIAL) begin
        m = addr_mask(w[`DSC_ADDR_HI:`DSC_ADDR_LO]);
        for (int i = 0; i < 16; i++) begin
          if (m[i]) begin
            case (w[`DSC_MODE_HI:`DSC_MODE_LO])
              `DSC_MODE_INPUT: begin
                if (s_r.bank) begin
                  s_nxt.in_b[i] = p;
                end else begin
                  s_nxt.in_a[i] = p;
                end
              end
              `DSC_MODE_OFFSET: s_nxt.ofs[i] = p;
              `DSC_MODE_GAIN: s_nxt.gain[i] = p;
              default: s_nxt.ofs[i] = s_r.ofs[i];
            endcase
          end
        end
        if (m != 16'h0000) begin
          if (s_r.s1_cnt != 11'd0) begin
            s_nxt.pace_err = 1'b1;
          end
          nch = ones(m);
          s1 = 11'(nch * `DSC_S1_CYC);
          s_nxt.s1_cnt = s1;
          s_nxt.busy_cnt = s1 + 11'(`DSC_S2_CYC + `DSC_S3_CYC);
        end
      end else begin
        case (w[`DSC_ADDR_HI:`DSC_ADDR_LO])
          `DSC_FC_CTRL_WR: s_nxt.bank = p[`DSC_CTRL_BANK];
          `DSC_FC_READBACK: begin
            case (p[`DSC_RB_KIND_HI:`DSC_RB_KIND_LO])
              `DSC_RB_INA: rd = s_r.in_a[p[`DSC_RB_CH_HI:`DSC_RB_CH_LO]];
              `DSC_RB_INB: rd = s_r.in_b[p[`DSC_RB_CH_HI:`DSC_RB_CH_LO]];
              `DSC_RB_OFS: rd = s_r.ofs[p[`DSC_RB_CH_HI:`DSC_RB_CH_LO]];
              `DSC_RB_GAIN: rd = s_r.gain[p[`DSC_RB_CH_HI:`DSC_RB_CH_LO]];
              `DSC_RB_CTRL: begin
                rd = ctrl_word(s_nxt.bank, s_r.crc_err);
                s_nxt.crc_err = 1'b0;
              end
              default: rd = 16'h0000;
            endcase
            s_nxt.rb_sh = {8'h00, rd};
            s_nxt.rb_left = 5'(`DSC_LEN_PLAIN);
            s_nxt.rb_oe = 1'b1;
          end
          default: s_nxt.rb_oe = s_r.rb_oe;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.fst <= FS_IDLE;
      s_r.sclk_m <= 1'b1;
      s_r.sclk_s <= 1'b1;
      s_r.sclk_d <= 1'b1;
      s_r.sync_m <= 1'b1;
      s_r.sync_s <= 1'b1;
      s_r.sync_d <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata = s_r.prdata;
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign sdo_o = s_r.rb_sh[23];
  assign sdo_oe = s_r.rb_oe;
  assign crc_error_out_n = ~s_r.crc_err;

endmodule

// File: rtl/dsc_defs.svh
// constants of the serial command decoder
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH

// ---------------------------------------------------------------
// frame layout
// ---------------------------------------------------------------
`define DSC_LEN_PLAIN 6'd24
`define DSC_LEN_CRC 6'd32
`define DSC_LEN_SAT 6'd33
`define DSC_MODE_HI 23
`define DSC_MODE_LO 22
`define DSC_ADDR_HI 21
`define DSC_ADDR_LO 16
`define DSC_MODE_SPECIAL 2'b00
`define DSC_MODE_GAIN 2'b01
`define DSC_MODE_OFFSET 2'b10
`define DSC_MODE_INPUT 2'b11
`define DSC_GRP_BCAST 2'b00
`define DSC_GRP_0 2'b01
`define DSC_GRP_1 2'b10
`define DSC_BC_ALL 3'b000
`define DSC_BC_G0 3'b001
`define DSC_BC_G1 3'b010
`define DSC_CRC_POLY 8'h07

// ---------------------------------------------------------------
// special function codes and readback selection
// ---------------------------------------------------------------
`define DSC_FC_CTRL_WR 6'h01
`define DSC_FC_READBACK 6'h05
`define DSC_RB_KIND_HI 6
`define DSC_RB_KIND_LO 4
`define DSC_RB_CH_HI 3
`define DSC_RB_CH_LO 0
`define DSC_RB_INA 3'd0
`define DSC_RB_INB 3'd1
`define DSC_RB_OFS 3'd2
`define DSC_RB_GAIN 3'd3
`define DSC_RB_CTRL 3'd4

// ---------------------------------------------------------------
// control and status bits, apb map
// ---------------------------------------------------------------
`define DSC_CTRL_BANK 2
`define DSC_CTRL_CRCERR 3
`define DSC_ST_BUSY 0
`define DSC_ST_STAGE1 1
`define DSC_ST_PACE 2
`define DSC_ST_RB 3
`define DSC_OFF_CTRL 12'h000
`define DSC_OFF_STATUS 12'h004

// ---------------------------------------------------------------
// recalculation timing
// ---------------------------------------------------------------
`define DSC_CLK_NS 10
`define DSC_STAGE1_NS 600
`define DSC_STAGE2_NS 600
`define DSC_STAGE3_NS 300
`define DSC_S1_CYC ((`DSC_STAGE1_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_S2_CYC ((`DSC_STAGE2_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_S3_CYC ((`DSC_STAGE3_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)

`endif

// File: rtl/dsc_pkg.sv
// types of the serial command decoder
package dsc_pkg;

  // ---------------------------------------------------------------
  // apb request bundle
  // ---------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } dsc_apb_req_s;

  // ---------------------------------------------------------------
  // frame receiver states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    FS_IDLE = 2'b01,
    FS_SHIFT = 2'b10
  } dsc_frame_e;

  // ---------------------------------------------------------------
  // state of the decoder except the crc register, which dsc_crc8 holds
  // ---------------------------------------------------------------
  typedef struct packed {
    logic sclk_m;
    logic sclk_s;
    logic sclk_d;
    logic sync_m;
    logic sync_s;
    logic sync_d;
    logic sdi_m;
    logic sdi_s;
    dsc_frame_e fst;
    logic [5:0] cnt;
    logic [31:0] shift;
    logic [15:0][15:0] in_a;
    logic [15:0][15:0] in_b;
    logic [15:0][15:0] ofs;
    logic [15:0][15:0] gain;
    logic bank;
    logic crc_err;
    logic pace_err;
    logic [10:0] s1_cnt;
    logic [10:0] busy_cnt;
    logic [23:0] rb_sh;
    logic [4:0] rb_left;
    logic rb_oe;
    logic [31:0] prdata;
  } dsc_state_s;

  typedef struct packed {
    logic [7:0] crc;
  } dsc_crc_state_s;

endpackage

// File: rtl/dsc_crc8.sv
// serial crc-8 accumulator, one bit per enable
`timescale 1ns/1ps
`include "dsc_defs.svh"
module dsc_crc8
  import dsc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bit stream
  input wire logic clr,
  input wire logic bit_en,
  input wire logic bit_in,
  // result
  output logic [7:0] crc
);

  dsc_crc_state_s s_r;
  dsc_crc_state_s s_nxt;
  logic fb;

  // ---------------------------------------------------------------
  // next value
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    fb = s_r.crc[7] ^ bit_in;
    if (clr) begin
      s_nxt.crc = 8'h00;
    end else if (bit_en) begin
      s_nxt.crc = {s_r.crc[6:0], 1'b0} ^ (fb ? `DSC_CRC_POLY : 8'h00);
    end
  end

  // ---------------------------------------------------------------
  // register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign crc = s_r.crc;

endmodule

// File: bench/dsc_decoder_props.sv
// port assertions of the serial command decoder
`timescale 1ns/1ps
`include "dsc_defs.svh"
module dsc_decoder_props
  import dsc_pkg::*;
#(
  parameter int NUM_CH = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input dsc_apb_req_s apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // serial pins
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdi,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic crc_error_out_n
);
  // ----------------------------------------
  // helpers and properties
  // ----------------------------------------
  logic rd_ctrl;
  assign rd_ctrl = apb_req.psel && apb_req.penable && !apb_req.pwrite &&
    apb_req.paddr == `DSC_OFF_CTRL;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_oe_rise_end: assert property (
    $rose(sdo_oe) |-> sync_n && $past(sync_n)) else $error("sdo driven inside frame");
  a_oe_fall_frame: assert property (
    $fell(sdo_oe) |-> !sync_n) else $error("sdo released outside frame");
  a_oe_hold_idle: assert property (
    sdo_oe && sync_n && $past(sync_n) |=> sdo_oe) else $error("sdo dropped before read");
  a_sdo_shift_frame: assert property (
    sdo_oe && $past(sdo_oe) && $changed(sdo_o) |-> !sync_n)
    else $error("sdo shifted between frames");
  a_err_fall_end: assert property (
    $fell(crc_error_out_n) |-> sync_n && $past(sync_n)) else $error("error set mid frame");
  a_err_after_rise: assert property (
    $fell(crc_error_out_n) |-> $past(sync_n, 2)) else $error("check before frame end");
  a_err_clear_read: assert property (
    rd_ctrl |-> ##[1:3] crc_error_out_n) else $error("error not cleared by read");
  a_err_rise_cause: assert property (
    $rose(crc_error_out_n) |-> $past(rd_ctrl) || $past(rd_ctrl, 2) || $past(rd_ctrl, 3)
    || (sync_n && !$past(sync_n, 4))) else $error("error cleared without read");
  c_readback: cover property ($rose(sdo_oe));
  c_crc_err: cover property ($fell(crc_error_out_n));
  c_ctrl_rd: cover property (rd_ctrl && !crc_error_out_n);
endmodule
bind dsc_decoder dsc_decoder_props #(.NUM_CH(NUM_CH)) dsc_decoder_props_inst (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sclk(sclk), .sync_n(sync_n), .sdi(sdi), .sdo_o(sdo_o),
  .sdo_oe(sdo_oe), .crc_error_out_n(crc_error_out_n));

// File: bench/dsc_host_model.sv
// host serial master model
`timescale 1ns/1ps
module dsc_host_model (
  // clock
  input wire logic pclk,
  // serial pins
  output logic sclk,
  output logic sync_n,
  output logic sdi,
  input wire logic sdo
);
  // ----------------------------------------
  // frame engine, 80 ns serial clock
  // ----------------------------------------
  logic [31:0] rx;
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    sdi = 1'b0;
  end
  // msb first, sdo taken at each fall
  task automatic frame(input logic [31:0] w, input int n);
    rx = '0;
    @(posedge pclk) sync_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi <= w[i];
      repeat (4) @(posedge pclk);
      rx = {rx[30:0], sdo};
      sclk <= 1'b0;
      repeat (4) @(posedge pclk);
      sclk <= 1'b1;
    end
    repeat (4) @(posedge pclk);
    sync_n <= 1'b1;
    sdi <= ~sdi;
    repeat (12) @(posedge pclk);
  endtask
endmodule

// File: bench/testbench.sv
// self-checking bench of the serial command decoder
`timescale 1ns/1ps
`include "dsc_defs.svh"
module testbench
  import dsc_pkg::*;
;
  // ----------------------------------------
  // signals, model and helpers
  // ----------------------------------------
  logic pclk, presetn, pready, pslverr, sclk, sync_n, sdi, sdo_o, sdo_oe, crc_error_out_n;
  logic sdo_w;
  dsc_apb_req_s apb_req;
  logic [31:0] prdata, lf;
  int error_cnt, n_tests, bank;
  int reg_m[4][16];
  assign sdo_w = sdo_oe ? sdo_o : ~sdo_o;
  dsc_decoder #(.NUM_CH(16)) dsc_decoder_inst (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk),
    .sync_n(sync_n), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .crc_error_out_n(crc_error_out_n));
  dsc_host_model dsc_host_model_inst (.pclk(pclk), .sclk(sclk), .sync_n(sync_n),
    .sdi(sdi), .sdo(sdo_w));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] crc8(input logic [23:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic final_report();
    $display("compares %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    apb_req <= '0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task automatic idle();
    logic [31:0] q;
    int k;
    k = 0;
    do begin
      rd(`DSC_OFF_STATUS, q);
      k++;
    end while (q[`DSC_ST_BUSY] !== 1'b0 && k < 400);
    chk(q[`DSC_ST_BUSY], 1'b0);
  endtask
  task automatic wr24(input logic [1:0] m, input logic [5:0] a, input logic [15:0] d);
    dsc_host_model_inst.frame({8'h00, m, a, d}, 24);
  endtask
  task automatic mwrite(input logic [1:0] m, input logic [5:0] a, input logic [15:0] d);
    int k;
    k = (m == 2'b11) ? bank : (m == 2'b10) ? 2 : 3;
    for (int c = 0; c < 16; c++)
      if ((a[5:3] == 3'b000 && (a[2:0] == 3'b000 || a[2:0] == 3'(1 + c / 8))) ||
          (a[5:3] == 3'(1 + c / 8) && a[2:0] == 3'(c % 8))) reg_m[k][c] = d;
    wr24(m, a, d);
  endtask
  task automatic rb(input int kind, input int ch, input int exp);
    wr24(2'b00, `DSC_FC_READBACK, 16'(kind * 16 + ch));
    chk(sdo_oe, 1'b1);
    dsc_host_model_inst.frame(32'h0, 24);
    chk(dsc_host_model_inst.rx, 32'(exp));
    chk(sdo_oe, 1'b0);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (90000) @(posedge pclk);
    error_cnt++;
    final_report();
  end
  initial begin
    logic [31:0] q;
    logic e;
    logic [1:0] m;
    logic [5:0] a;
    logic [23:0] w;
    int c;
    apb_req = '0;
    presetn = 1'b0;
    error_cnt = 0;
    n_tests = 0;
    bank = 0;
    lf = 32'h696d;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`DSC_OFF_CTRL, q);
    chk(q, 32'h0);
    apb(1'b0, 12'h008, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    bank = 1;
    apb(1'b1, `DSC_OFF_CTRL, 32'h4, q, e);
    mwrite(2'b11, 6'h00, 16'h1234);
    idle();
    bank = 0;
    apb(1'b1, `DSC_OFF_CTRL, 32'h0, q, e);
    for (int i = 1; i < 4; i++) begin
      mwrite(2'(i), 6'h00, 16'(i * 16'h1111));
      idle();
    end
    $display("done: fill");
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      m = (lf[1:0] == 2'b00) ? 2'b11 : lf[1:0];
      a = (i < 2) ? 6'(i + 1) : {1'b0, lf[2] ? 2'b10 : 2'b01, lf[5:3]};
      c = {(i < 2) ? a[1] : a[4], lf[5:3]};
      mwrite(m, a, lf[31:16]);
      rd(`DSC_OFF_STATUS, q);
      chk(q[1:0], 2'b11);
      idle();
      rb(m == 2'b11 ? bank : m == 2'b10 ? 2 : 3, c, reg_m[m == 2'b11 ? bank : 4 - m][c]);
      rb(3 - m[0], c ^ 8, reg_m[3 - m[0]][c ^ 8]);
    end
    $display("done: modes");
    mwrite(2'b10, 6'h00, 16'hbeef);
    mwrite(2'b01, 6'h0a, 16'h5a5a);
    rd(`DSC_OFF_STATUS, q);
    chk(q[`DSC_ST_PACE], 1'b1);
    apb(1'b1, `DSC_OFF_STATUS, 32'h4, q, e);
    idle();
    mwrite(2'b11, 6'h11, 16'h0f0f);
    mwrite(2'b11, 6'h12, 16'hf0f0);
    rd(`DSC_OFF_STATUS, q);
    chk(q[`DSC_ST_PACE], 1'b0);
    idle();
    rb(2, 13, reg_m[2][13]);
    rb(3, 2, reg_m[3][2]);
    $display("done: pacing");
    wr24(2'b00, `DSC_FC_CTRL_WR, 16'h0004);
    bank = 1;
    rd(`DSC_OFF_CTRL, q);
    chk(q, 32'h4);
    mwrite(2'b11, 6'h15, lf[15:0]);
    idle();
    rb(1, 13, reg_m[1][13]);
    rb(0, 13, reg_m[0][13]);
    wr24(2'b00, `DSC_FC_CTRL_WR, 16'h0000);
    bank = 0;
    w = {2'b11, 6'h09, 16'h3c3c};
    dsc_host_model_inst.frame({w, crc8(w)}, 32);
    reg_m[0][1] = 16'h3c3c;
    chk(crc_error_out_n, 1'b1);
    w = {2'b10, 6'h09, 16'hdead};
    dsc_host_model_inst.frame({w, crc8(w) ^ 8'h01}, 32);
    chk(crc_error_out_n, 1'b0);
    rd(`DSC_OFF_CTRL, q);
    chk(q, 32'h8);
    rd(`DSC_OFF_CTRL, q);
    chk({q[30:0], crc_error_out_n}, 32'h1);
    idle();
    rb(0, 1, reg_m[0][1]);
    rb(2, 1, reg_m[2][1]);
    $display("done: crc");
    w = {2'b11, 6'h0b, 16'h7777};
    dsc_host_model_inst.frame(32'(w >> 1), 23);
    dsc_host_model_inst.frame({w, 1'b0}, 25);
    wr24(2'b11, 6'h1b, 16'h7777);
    wr24(2'b11, 6'h03, 16'h7777);
    wr24(2'b11, 6'h23, 16'h7777);
    rd(`DSC_OFF_STATUS, q);
    chk({q[31:1], crc_error_out_n}, 32'h1);
    rb(0, 3, reg_m[0][3]);
    rb(4, 0, 0);
    $display("done: ignored frames");
    final_report();
  end
endmodule
